//--- touch_status_query_cmds.sv
`timescale 1ns/1ns
`default_nettype none
// Operation
// - 0x06 returns status byte plus check byte
// - Bit 6 flags any alert condition
// - Bits 5-0 first key, 0x3f none
// - Check byte is CRC-8 over command, data
// - 0x07 returns six detect bytes plus CRC
// - 0x08 returns 48 signal words, low first
// - 0x09 returns 48 reference words, low first
// - 0x0a returns 48 reference-minus-signal bytes
// - 0x0c returns fault byte plus CRC
// - Scanning suspended during setups dump
// - Dump is setups then CRC-16 low first
// - Dump aborts after 100 ms byte gap
// - 0x0e returns setups CRC-16 low first
// - 0x0f returns complement of previous command
// - 0x10 returns code byte plus CRC
// - Unknown command sets comms error flag
module touch_status_query_cmds
   import touch_query_pkg::*;
#(
   parameter int          GAP_CYCLES  = touch_query_pkg::DUMP_GAP_CYC,
   parameter int          SETUP_LEN   = touch_query_pkg::SETUP_BYTES,
   parameter logic [7:0]  CRC8_P      = touch_query_pkg::CRC8_POLY,
   parameter logic [7:0]  CRC8_I      = touch_query_pkg::CRC8_INIT,
   parameter logic [15:0] CRC16_P     = touch_query_pkg::CRC16_POLY,
   parameter logic [15:0] CRC16_I     = touch_query_pkg::CRC16_INIT
) (
   input  wire logic        ref_clk_in,
   input  wire logic        rst_n_in,
   input  wire logic [7:0]  cmd_data_in,
   input  wire logic        cmd_valid_in,
   output logic             cmd_ready_out,
   output logic [7:0]       resp_data_out,
   output logic             resp_valid_out,
   input  wire logic        resp_ready_in,
   input  wire logic [47:0] key_detect_in,
   input  wire logic [47:0] key_error_in,
   input  wire logic        any_cal_in,
   input  wire logic        cal_fail_in,
   input  wire logic        sync_fail_in,
   input  wire logic        fault_fail_in,
   input  wire logic        setup_corrupt_in,
   input  wire logic [7:0]  fault_bits_in,
   input  wire logic [7:0]  internal_code_in,
   input  wire logic [15:0] setup_crc_in,
   output logic [5:0]       key_index_out,
   input  wire logic [15:0] key_signal_in,
   input  wire logic [15:0] key_ref_in,
   output logic [7:0]       setup_addr_out,
   input  wire logic [7:0]  setup_byte_in,
   output logic             scan_hold_out,
   output logic             comms_error_out,
   output logic             dump_abort_out
);
   import touch_query_pkg::*;

   initial begin
      if (GAP_CYCLES < 1 || GAP_CYCLES >= (1 << 23) ||
          SETUP_LEN < 1 || SETUP_LEN > 256) begin
         $error("touch_status_query_cmds: bad parameter");
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // CRC helpers; MSB first, no reflection, no final inversion, so
   // the setups-load checker can share the same parameters
   function automatic logic [7:0] crc8_step(input logic [7:0] c,
                                            input logic [7:0] d);
      logic [7:0] r;
      r = c ^ d;
      for (int i = 0; i < 8; i++) begin
         r = r[7] ? ((r << 1) ^ CRC8_P) : (r << 1);
      end
      return r;
   endfunction

   function automatic logic [15:0] crc16_step(input logic [15:0] c,
                                              input logic [7:0]  d);
      logic [15:0] r;
      r = c ^ {d, 8'h00};
      for (int i = 0; i < 8; i++) begin
         r = r[15] ? ((r << 1) ^ CRC16_P) : (r << 1);
      end
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Response engine state
   resp_state_e state;
   logic [7:0]  cur_op;
   logic [7:0]  last_cmd;
   logic [7:0]  prev_cmd;
   logic [8:0]  idx;
   logic [8:0]  count;
   logic [7:0]  crc8;
   logic [15:0] crc16;
   logic [22:0] gap_cnt;
   logic        cmd_fire;
   logic        known;
   logic [7:0]  byte_val;
   logic [7:0]  wr_data;
   logic        wr_valid;
   logic        wr_ready;
   logic [7:0]  delta;
   logic        alert;
   logic        multi;
   logic [5:0]  first_key;

   // Commands accepted only between responses, keeping order; a host
   // that writes early just sees its byte held off until idle
   assign cmd_ready_out = (state == ST_IDLE);
   assign cmd_fire      = cmd_valid_in && cmd_ready_out;

   // Opcode recognition; null is a valid filler byte
   // Opcodes of other command groups fall to default as unknown
   always_comb begin
      case (cmd_data_in)
         OP_NULL, OP_FIRST_KEY, OP_ALL_KEYS, OP_SIGNALS, OP_REFS,
         OP_DELTAS, OP_ERRORS, OP_FAULT, OP_DUMP, OP_SETUP_CRC,
         OP_LAST_CMD, OP_INT_CODE: known = 1'b1;
         default: known = 1'b0;
      endcase
   end

   // Priority encode the first touched key
   always_comb begin
      first_key = NO_KEY;
      for (int k = NUM_KEYS - 1; k >= 0; k--) begin
         if (key_detect_in[k]) begin
            first_key = 6'(k);
         end
      end
   end

   // Flag summary; comms error fed back so a bad byte shows up here
   assign multi = ($countones(key_detect_in) > 1);
   assign alert = any_cal_in | cal_fail_in | sync_fail_in | comms_error_out |
                  fault_fail_in | setup_corrupt_in;

   // Reference minus signal, held within one byte; a signal above its
   // reference wraps instead of saturating, which keeps the path short
   assign delta = 8'(key_ref_in - key_signal_in);

   // Key and setups addresses follow the byte index
   assign key_index_out  = (cur_op == OP_DELTAS) ? 6'(idx) : 6'(idx >> 1);
   assign setup_addr_out = idx[7:0];

   // Data byte for the current index
   always_comb begin
      case (cur_op)
         OP_FIRST_KEY: byte_val = {multi, alert, first_key};
         OP_ALL_KEYS:  byte_val = key_detect_in[idx[2:0]*8 +: 8];
         OP_ERRORS:    byte_val = key_error_in[idx[2:0]*8 +: 8];
         OP_SIGNALS:   byte_val = idx[0] ? key_signal_in[15:8]
                                         : key_signal_in[7:0];
         OP_REFS:      byte_val = idx[0] ? key_ref_in[15:8]
                                         : key_ref_in[7:0];
         OP_DELTAS:    byte_val = delta;
         OP_FAULT:     byte_val = fault_bits_in;
         OP_DUMP:      byte_val = setup_byte_in;
         OP_SETUP_CRC: byte_val = idx[0] ? setup_crc_in[15:8]
                                         : setup_crc_in[7:0];
         OP_LAST_CMD:  byte_val = ~prev_cmd;
         OP_INT_CODE:  byte_val = internal_code_in;
         default:      byte_val = 8'h00;
      endcase
   end

   // Byte pushed into the FIFO per state
   // CRC bytes come from registers updated on the previous write
   always_comb begin
      case (state)
         ST_EMIT:   wr_data = byte_val;
         ST_CRC8:   wr_data = crc8;
         ST_CRC16:  wr_data = crc16[7:0];
         ST_CRC16H: wr_data = crc16[15:8];
         default:   wr_data = 8'h00;
      endcase
   end
   assign wr_valid = (state != ST_IDLE);

   ////////////////////////////////////////////////////////////////////////
   // Sequencer: one byte per slot, stalled by FIFO back-pressure
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state  <= ST_IDLE;
         cur_op <= 8'h00;
         idx    <= '0;
         count  <= '0;
         crc8   <= 8'h00;
         crc16  <= 16'h0000;
      end else begin
         case (state)
            ST_IDLE: begin
               if (cmd_fire && known && cmd_data_in != OP_NULL) begin
                  cur_op <= cmd_data_in;
                  idx    <= '0;
                  crc8   <= crc8_step(CRC8_I, cmd_data_in);
                  crc16  <= CRC16_I;
                  state  <= ST_EMIT;
                  case (cmd_data_in)
                     OP_ALL_KEYS, OP_ERRORS: count <= 9'd6;
                     OP_SIGNALS, OP_REFS:    count <= 9'(2 * NUM_KEYS);
                     OP_DELTAS:              count <= 9'(NUM_KEYS);
                     OP_DUMP:                count <= 9'(SETUP_LEN);
                     OP_SETUP_CRC:           count <= 9'd2;
                     default:                count <= 9'd1;
                  endcase
               end
            end
            ST_EMIT: begin
               // Timeout wins over a pending byte, nothing follows it
               if (gap_cnt == 23'(GAP_CYCLES)) begin
                  state <= ST_IDLE;
               end else if (wr_ready) begin
                  crc8  <= crc8_step(crc8, byte_val);
                  crc16 <= crc16_step(crc16, byte_val);
                  idx   <= idx + 9'd1;
                  if (idx == count - 9'd1) begin
                     case (cur_op)
                        OP_FIRST_KEY, OP_ALL_KEYS, OP_ERRORS,
                        OP_FAULT, OP_INT_CODE: state <= ST_CRC8;
                        OP_DUMP: state <= ST_CRC16;
                        default: state <= ST_IDLE;
                     endcase
                  end
               end
            end
            ST_CRC8: begin
               if (wr_ready) begin
                  state <= ST_IDLE;
               end
            end
            ST_CRC16: begin
               // The check word may be cut short by a timeout as well
               if (gap_cnt == 23'(GAP_CYCLES)) begin
                  state <= ST_IDLE;
               end else if (wr_ready) begin
                  state <= ST_CRC16H;
               end
            end
            ST_CRC16H: begin
               if (gap_cnt == 23'(GAP_CYCLES) || wr_ready) begin
                  state <= ST_IDLE;
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   // Inter-byte gap timer on the host side of the dump
   // Stalls from a full FIFO count too: only a host pop restarts it
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         gap_cnt <= '0;
      end else if (cur_op != OP_DUMP || state == ST_IDLE ||
                   (resp_valid_out && resp_ready_in)) begin
         gap_cnt <= '0;
      end else if (gap_cnt != 23'(GAP_CYCLES)) begin
         gap_cnt <= gap_cnt + 23'd1;
      end
   end

   // Abort pulse, one cycle
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         dump_abort_out <= 1'b0;
      end else begin
         dump_abort_out <= (state != ST_IDLE) && (cur_op == OP_DUMP) &&
                           (gap_cnt == 23'(GAP_CYCLES));
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Scanning held for the whole dump, released on completion; kept
   // until the queue drains, as the host is still reading setups bytes
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         scan_hold_out <= 1'b0;
      end else if (cmd_fire && cmd_data_in == OP_DUMP) begin
         scan_hold_out <= 1'b1;
      end else if (state == ST_IDLE && !resp_valid_out) begin
         scan_hold_out <= 1'b0;
      end
   end

   // Previous command byte, recorded on the edge it is taken
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         last_cmd <= 8'h00;
      end else if (cmd_fire && cmd_data_in != OP_NULL) begin
         last_cmd <= cmd_data_in;
      end
   end

   // Command before the current one, for the echo; last_cmd already
   // holds the echo opcode itself once that opcode is taken
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         prev_cmd <= 8'h00;
      end else if (cmd_fire && cmd_data_in != OP_NULL) begin
         prev_cmd <= last_cmd;
      end
   end

   // Comms error: set wins over clear
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         comms_error_out <= 1'b0;
      end else if (cmd_fire && !known) begin
         comms_error_out <= 1'b1;
      end else if (cmd_fire && cmd_data_in == OP_LAST_CMD) begin
         comms_error_out <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Response buffer toward the port; host pops on resp_ready_in drain it
   // Writes are cut once the dump gap expires, so no byte follows it
   resp_fifo #(
      .WIDTH (FIFO_WIDTH),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .ref_clk_in   (ref_clk_in),
      .rst_n_in     (rst_n_in),
      .wr_data_in   (wr_data),
      .wr_valid_in  (wr_valid && gap_cnt != 23'(GAP_CYCLES)),
      .wr_ready_out (wr_ready),
      .rd_data_out  (resp_data_out),
      .rd_valid_out (resp_valid_out),
      .rd_ready_in  (resp_ready_in)
   );
endmodule
`default_nettype wire

//--- touch_query_pkg.sv
package touch_query_pkg;
   // Opcodes served by this decoder
   localparam logic [7:0] OP_NULL       = 8'h00;
   localparam logic [7:0] OP_FIRST_KEY  = 8'h06;
   localparam logic [7:0] OP_ALL_KEYS   = 8'h07;
   localparam logic [7:0] OP_SIGNALS    = 8'h08;
   localparam logic [7:0] OP_REFS       = 8'h09;
   localparam logic [7:0] OP_DELTAS     = 8'h0a;
   localparam logic [7:0] OP_ERRORS     = 8'h0b;
   localparam logic [7:0] OP_FAULT      = 8'h0c;
   localparam logic [7:0] OP_DUMP       = 8'h0d;
   localparam logic [7:0] OP_SETUP_CRC  = 8'h0e;
   localparam logic [7:0] OP_LAST_CMD   = 8'h0f;
   localparam logic [7:0] OP_INT_CODE   = 8'h10;
   // Status byte layout
   localparam int MULTI_BIT  = 7;
   localparam int ALERT_BIT  = 6;
   localparam logic [5:0] NO_KEY = 6'h3f;
   // Key and setups geometry
   localparam int NUM_KEYS    = 48;
   localparam int SETUP_BYTES = 247;
   // CRC defaults, shared with setups-load logic
   localparam logic [7:0]  CRC8_POLY  = 8'h31;
   localparam logic [7:0]  CRC8_INIT  = 8'h00;
   localparam logic [15:0] CRC16_POLY = 16'h1021;
   localparam logic [15:0] CRC16_INIT = 16'h0000;
   // Dump inter-byte timeout
   localparam int CLK_HZ        = 10_000_000;
   localparam int DUMP_GAP_MS   = 100;
   localparam int DUMP_GAP_CYC  = CLK_HZ / 1000 * DUMP_GAP_MS;
   // Response FIFO
   localparam int FIFO_DEPTH = 32;
   localparam int FIFO_WIDTH = 8;
   // Response engine states
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_EMIT  = 3'b001,
      ST_CRC8  = 3'b010,
      ST_CRC16 = 3'b011,
      ST_CRC16H = 3'b100
   } resp_state_e;
endpackage

//--- resp_fifo.sv
`timescale 1ns/1ns
`default_nettype none
module resp_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32
) (
   input  wire logic             ref_clk_in,
   input  wire logic             rst_n_in,
   input  wire logic [WIDTH-1:0] wr_data_in,
   input  wire logic             wr_valid_in,
   output logic                  wr_ready_out,
   output logic      [WIDTH-1:0] rd_data_out,
   output logic                  rd_valid_out,
   input  wire logic             rd_ready_in
);
   localparam int AW = $clog2(DEPTH);
   initial begin
      if (DEPTH < 2 || (1 << AW) != DEPTH) begin
         $error("resp_fifo depth must be a power of two");
      end
   end

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wr_ptr;
   logic [AW:0]      rd_ptr;
   logic             full;
   logic             empty;

   // Extra pointer bit separates full from empty
   assign full  = (wr_ptr[AW] != rd_ptr[AW]) &&
                  (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
   assign empty = (wr_ptr == rd_ptr);
   assign wr_ready_out = !full;
   assign rd_valid_out = !empty;
   assign rd_data_out  = mem[rd_ptr[AW-1:0]];

   // Storage write, no reset needed
   always_ff @(posedge ref_clk_in) begin
      if (wr_valid_in && !full) begin
         mem[wr_ptr[AW-1:0]] <= wr_data_in;
      end
   end

   // Pointers
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end else begin
         if (wr_valid_in && !full) begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (rd_ready_in && !empty) begin
            rd_ptr <= rd_ptr + 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

//--- touch_status_query_cmds_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module touch_status_query_cmds_monitor
   import touch_query_pkg::*;
(
   input  wire logic       ref_clk_in,
   input  wire logic       rst_n_in,
   input  wire logic [7:0] cmd_data_in,
   input  wire logic       cmd_valid_in,
   input  wire logic       cmd_ready_out,
   input  wire logic [7:0] resp_data_out,
   input  wire logic       resp_valid_out,
   input  wire logic       resp_ready_in,
   input  wire logic       scan_hold_out,
   input  wire logic       comms_error_out,
   input  wire logic       dump_abort_out
);
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (!rst_n_in);
   logic fire;
   // Command byte taken on this edge
   assign fire = cmd_valid_in && cmd_ready_out;
   ////////////////////////////////////////////////////////////////////////////
   chk_first_busy: assert property (fire && cmd_data_in == OP_FIRST_KEY |=> !cmd_ready_out)
      else $error("engine idle right after first-key command");
   chk_first_resp: assert property (fire && cmd_data_in == OP_FIRST_KEY |-> ##2 resp_valid_out)
      else $error("no response two cycles after first-key command");
   chk_first_done: assert property (fire && cmd_data_in == OP_FIRST_KEY |-> ##[3:60] cmd_ready_out)
      else $error("engine stuck after first-key command");
   chk_null_quiet: assert property (fire && cmd_data_in == OP_NULL && !resp_valid_out |=> cmd_ready_out && !resp_valid_out)
      else $error("null command produced a response");
   chk_dump_hold: assert property (fire && cmd_data_in == OP_DUMP |-> ##[1:2] scan_hold_out)
      else $error("scanning not held for dump");
   chk_abort_pulse: assert property (dump_abort_out |=> !dump_abort_out)
      else $error("abort longer than one cycle");
   chk_err_set: assert property (fire && cmd_data_in > OP_INT_CODE |-> ##[1:2] comms_error_out)
      else $error("unknown command left error flag low");
   chk_err_clear: assert property (fire && cmd_data_in == OP_LAST_CMD |-> ##[1:2] !comms_error_out)
      else $error("last-command did not clear error flag");
   chk_head_hold: assert property (resp_valid_out && !resp_ready_in |=> resp_valid_out && $stable(resp_data_out))
      else $error("response head changed while stalled");
   // Main scenarios reached
   cover property (fire && cmd_data_in == OP_DUMP);
   cover property (dump_abort_out);
   cover property (resp_valid_out && !resp_ready_in && !cmd_ready_out);
endmodule
bind touch_status_query_cmds touch_status_query_cmds_monitor mon (
   .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .cmd_data_in(cmd_data_in),
   .cmd_valid_in(cmd_valid_in), .cmd_ready_out(cmd_ready_out),
   .resp_data_out(resp_data_out), .resp_valid_out(resp_valid_out),
   .resp_ready_in(resp_ready_in), .scan_hold_out(scan_hold_out),
   .comms_error_out(comms_error_out), .dump_abort_out(dump_abort_out));
`default_nettype wire

//--- host_reader.sv
`timescale 1ns/1ns
`default_nettype none
module host_reader (
   input  wire logic       ref_clk_in,
   input  wire logic       rst_n_in,
   input  wire logic [1:0] mode_in,
   output logic            ready_out
);
   // Mode 0 prompt, 1 stalls often, 2 halted so the dump gap can expire
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ready_out <= 1'b0;
      end else begin
         ready_out <= mode_in == 2'd0 || (mode_in == 2'd1 && $urandom % 4 == 0);
      end
   end
endmodule
`default_nettype wire

//--- test_touch_status_query_cmds.sv
`timescale 1ns/1ns
`default_nettype none
module test_touch_status_query_cmds;
   import touch_query_pkg::*;
   localparam int GAP = 50;
   logic        ref_clk_in = 1'b0, rst_n_in = 1'b0, cmd_valid = 1'b0;
   logic [7:0]  cmd_data = '0, fbits = '0, icode = '0, smask = '0, prev = '0;
   logic [1:0]  mode = 2'd1;
   logic [47:0] detect = '0, kerr = '0;
   logic [4:0]  fl = '0;
   logic [15:0] scrc = '0, sig_base = '0, ref_base = '0, ksig, kref;
   logic        cmd_ready, resp_valid, resp_ready, hold, cerr, abort, ecomm = 1'b0;
   logic [7:0]  resp_data, saddr, sbyte;
   logic [5:0]  kidx;
   logic [7:0]  q[$], exp[$];
   int          err_total = 0, n_checks = 0, i;
   // Sensing and setups memory answer combinationally
   assign ksig  = sig_base + 16'(kidx) * 16'h0003;
   assign kref  = ref_base + 16'(kidx) * 16'h0007;
   assign sbyte = saddr ^ smask;
   always #50 ref_clk_in = ~ref_clk_in;
   // Record a byte at the negedge before the edge that pops it
   always @(negedge ref_clk_in) if (rst_n_in && resp_valid && resp_ready) q.push_back(resp_data);
   touch_status_query_cmds #(.GAP_CYCLES(GAP)) dut (
      .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .cmd_data_in(cmd_data),
      .cmd_valid_in(cmd_valid), .cmd_ready_out(cmd_ready), .resp_data_out(resp_data),
      .resp_valid_out(resp_valid), .resp_ready_in(resp_ready), .key_detect_in(detect),
      .key_error_in(kerr), .any_cal_in(fl[0]), .cal_fail_in(fl[1]), .sync_fail_in(fl[2]),
      .fault_fail_in(fl[3]), .setup_corrupt_in(fl[4]), .fault_bits_in(fbits),
      .internal_code_in(icode), .setup_crc_in(scrc), .key_index_out(kidx),
      .key_signal_in(ksig), .key_ref_in(kref), .setup_addr_out(saddr),
      .setup_byte_in(sbyte), .scan_hold_out(hold), .comms_error_out(cerr),
      .dump_abort_out(abort));
   host_reader host (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .mode_in(mode),
      .ready_out(resp_ready));
   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [7:0] crc8(logic [7:0] c, logic [7:0] b);
      c ^= b;
      repeat (8) c = c[7] ? (c << 1) ^ CRC8_POLY : c << 1;
      return c;
   endfunction
   function automatic logic [15:0] crc16(logic [15:0] c, logic [7:0] b);
      c ^= {b, 8'h00};
      repeat (8) c = c[15] ? (c << 1) ^ CRC16_POLY : c << 1;
      return c;
   endfunction
   task automatic final_report;
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic stop;
      err_total++;
      final_report;
   endtask
   task automatic chk(string name, logic [7:0] e, logic [7:0] g);
      n_checks++;
      if (g !== e) begin
         err_total++;
         $display("BAD %s expected %h seen %h", name, e, g);
      end
   endtask
   // Expected answer from the inputs as they stand now
   task automatic build(logic [7:0] op);
      int f;
      logic [15:0] w, c;
      exp.delete();
      f = 63;
      c = CRC16_INIT;
      for (int k = 0; k < 48; k++) begin
         if (detect[47 - k]) f = 47 - k;
         w = op == OP_SIGNALS ? sig_base + 16'(k) * 16'h0003 : ref_base + 16'(k) * 16'h0007;
         if (op inside {OP_SIGNALS, OP_REFS}) exp.push_back(w[7:0]);
         if (op inside {OP_SIGNALS, OP_REFS}) exp.push_back(w[15:8]);
         w = 16'(k) * 16'h0004 + ref_base - sig_base;
         if (op == OP_DELTAS) exp.push_back(w[7:0]);
      end
      for (int j = 0; j < 6; j++) begin
         if (op == OP_ALL_KEYS) exp.push_back(detect[8*j +: 8]);
         if (op == OP_ERRORS) exp.push_back(kerr[8*j +: 8]);
      end
      if (op == OP_FIRST_KEY) exp.push_back({$countones(detect) > 1, |fl | ecomm, 6'(f)});
      if (op == OP_FAULT) exp.push_back(fbits);
      if (op == OP_INT_CODE) exp.push_back(icode);
      if (op == OP_SETUP_CRC) exp = {scrc[7:0], scrc[15:8]};
      if (op == OP_LAST_CMD) exp = {~prev};
      for (int a = 0; a < SETUP_BYTES && op == OP_DUMP; a++) begin
         exp.push_back(8'(a) ^ smask);
         c = crc16(c, 8'(a) ^ smask);
      end
      if (op == OP_DUMP) exp = {exp, c[7:0], c[15:8]};
      c[7:0] = crc8(CRC8_INIT, op);
      foreach (exp[j]) c[7:0] = crc8(c[7:0], exp[j]);
      if (op inside {OP_FIRST_KEY, OP_ALL_KEYS, OP_ERRORS, OP_FAULT, OP_INT_CODE})
         exp.push_back(c[7:0]);
   endtask
   task automatic send(logic [7:0] c);
      @(posedge ref_clk_in);
      cmd_data  <= c;
      cmd_valid <= 1'b1;
      for (i = 0; i < 3000 && cmd_ready !== 1'b1; i++) @(negedge ref_clk_in);
      if (i == 3000) stop();
      @(posedge ref_clk_in);
      cmd_valid <= 1'b0;
   endtask
   task automatic run(logic [7:0] op);
      build(op);
      q.delete();
      send(op);
      if (op != OP_NULL) prev = op;
      if (op > OP_INT_CODE) ecomm = 1'b1;
      if (op == OP_LAST_CMD) ecomm = 1'b0;
      for (i = 0; i < 3000 && q.size() < exp.size(); i++) @(negedge ref_clk_in);
      if (i == 3000) stop();
      repeat (8) @(negedge ref_clk_in);
      chk("count", 8'(exp.size()), 8'(q.size()));
      foreach (exp[j]) chk("byte", exp[j], j < q.size() ? q[j] : ~exp[j]);
   endtask
   // New random sensing state, with empty and single-key corners
   task automatic shake(int r);
      @(posedge ref_clk_in);
      detect   <= r == 0 ? '0 : r == 1 ? 48'h1 << ($urandom % 48) : 48'({$urandom, $urandom});
      kerr     <= 48'({$urandom, $urandom});
      fl       <= r == 3 ? 5'($urandom) : 5'h00;
      {fbits, icode, scrc} <= 32'($urandom);
      {sig_base, ref_base} <= 32'($urandom);
      smask    <= 8'($urandom);
      mode     <= 2'($urandom % 2);
      @(negedge ref_clk_in); // Settle before expectations are built
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(20695));
      repeat (16) @(posedge ref_clk_in);
      rst_n_in <= 1'b1;
      @(negedge ref_clk_in);
      chk("ready", 8'h01, {7'h0, cmd_ready});
      chk("valid", 8'h00, {7'h0, resp_valid});
      for (int n = 0; n < 30; n++) begin
         shake($urandom % 4);
         run(8'(n % 9 + 6) == OP_DUMP ? OP_INT_CODE : 8'(n % 9 + 6));
      end
      shake(0);
      run(8'h33);
      chk("comms_error", 8'h01, {7'h0, cerr});
      run(OP_FIRST_KEY);
      run(OP_NULL);
      run(OP_LAST_CMD);
      chk("comms_error", 8'h00, {7'h0, cerr});
      run(OP_LAST_CMD);
      shake(1);
      run(OP_DUMP);
      chk("scan_hold", 8'h00, {7'h0, hold});
      @(posedge ref_clk_in);
      mode <= 2'd2;
      q.delete();
      send(OP_DUMP);
      for (i = 0; i < 500 && abort !== 1'b1; i++) @(negedge ref_clk_in);
      chk("abort", 8'h01, {7'h0, abort});
      chk("scan_hold", 8'h01, {7'h0, hold});
      @(posedge ref_clk_in);
      mode <= 2'd0;
      repeat (100) @(negedge ref_clk_in);
      chk("kept", 8'(FIFO_DEPTH), 8'(q.size()));
      foreach (q[j]) chk("kept_byte", 8'(j) ^ smask, q[j]);
      chk("scan_hold", 8'h00, {7'h0, hold});
      final_report;
   end
endmodule
`default_nettype wire
